// *** dv/swt_mcu_model.sv ***
// Controller model that kicks the watchdog with falling edges.
`timescale 1ns/1ps
module swt_mcu_model #(
  parameter int PERIOD = 60
) (
  // Clock and control
  input wire logic mclk,
  input wire logic kick_en,
  // Kick line
  output logic kick_input
);
  int cnt;
  // Low phase of 4 cycles keeps both phases above one tick
  // One process owns the line, so it has a single driver
  initial begin
    kick_input = 1'b1;
    cnt = 0;
    forever begin
      @(negedge mclk);
      cnt <= (cnt + 1) % PERIOD;
      kick_input <= !(kick_en && cnt < 4); // One fall per period
    end
  end
endmodule

// *** dv/swt_tb.sv ***
// Self-checking testbench for the supply watchdog timer.
`timescale 1ns/1ps
module testbench;
  import swt_pkg::*;
  logic mclk, rst_n, supply_low, disable_level, kick_en;
  logic kick_input, shared_fault_out, shared_fault_oe_n;
  swt_state_t wd_state;
  int errors, checked, n;
  // Short counts keep the run small; one tick is two cycles.
  // Filter keeps its default of 200 ticks, about 400 cycles
  swt_watchdog #(.RESET_DELAY_TICKS(20), .IGNORE_TICKS(30),
    .DEADLINE_TICKS(50), .FAULT_TICKS(10),
    .TICK_DIV(2)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .supply_low(supply_low), .kick_input(kick_input),
    .disable_level(disable_level), .shared_fault_out(shared_fault_out),
    .shared_fault_oe_n(shared_fault_oe_n), .wd_state(wd_state));
  swt_mcu_model mcu_u (.mclk(mclk), .kick_en(kick_en),
    .kick_input(kick_input));
  // ---------------------------------------------
  // Checking helpers
  // ---------------------------------------------
  task automatic finish_test();
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // Free-running tick phase allows a tick of slack either way
  task automatic rng(input int v, input int lo, input int hi);
    chk((v >= lo && v <= hi) ? lo : v, lo);
  endtask
  // Cycles the pin stays at one level, bounded
  task automatic run_len(input logic lvl, input int lim);
    n = 0;
    while (shared_fault_oe_n === lvl && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (n >= lim) begin errors++; finish_test(); end
  endtask
  task automatic wait_st(input swt_state_t s, input int lim);
    n = 0;
    while (wd_state !== s && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (n >= lim) begin errors++; finish_test(); end
  endtask
  // Count cycles with the pin pulled low over a window
  task automatic lows(input int len);
    int k;
    k = 0;
    repeat (len) begin
      @(negedge mclk);
      if (shared_fault_oe_n !== 1'b1) k++;
    end
    n = k;
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_power();
    run_len(1'b0, 100);
    rng(n, 36, 44);
    chk(wd_state, SWT_IGNORE);
    chk(shared_fault_out, 1'b0);
    run_len(1'b1, 400);
    rng(n, 156, 166);
    chk(wd_state, SWT_FAULT);
    run_len(1'b0, 100);
    rng(n, 18, 22);
    chk(wd_state, SWT_IGNORE);
  endtask
  task automatic t_kick();
    kick_en <= 1'b1;
    lows(800);
    chk(n, 0);
    chk(wd_state, SWT_TRIGGER);
    kick_en <= 1'b0;
    run_len(1'b1, 200);
    rng(n, 40, 106);
    run_len(1'b0, 100);
  endtask
  task automatic t_disable();
    disable_level = 1'b1;
    repeat (390) @(negedge mclk);
    chk(wd_state === SWT_DISABLED, 1'b0);
    wait_st(SWT_DISABLED, 810);
    chk(wd_state, SWT_DISABLED);
    lows(400);
    chk(n, 0);
    disable_level = 1'b0;
    wait_st(SWT_IGNORE, 1000);
    rng(n, 396, 410);
  endtask
  // Disable lands inside a fault pulse: the pulse must still finish
  task automatic t_fault_dis();
    int k;
    k = 0;
    wait_st(SWT_FAULT, 400);
    // Pulses repeat every 180 cycles; filter ends about 546 cycles on
    repeat (145) @(negedge mclk);
    disable_level = 1'b1;
    n = 0;
    while (wd_state !== SWT_DISABLED && n < 600) begin
      @(negedge mclk);
      n++;
      if (shared_fault_oe_n !== 1'b1) k++;
    end
    if (n >= 600) begin errors++; finish_test(); end
    rng(k, 57, 63);
    chk(shared_fault_oe_n, 1'b1);
  endtask
  task automatic t_supply();
    supply_low = 1'b1;
    repeat (2) @(negedge mclk);
    chk(shared_fault_oe_n, 1'b0);
    chk(wd_state, SWT_RESET_DELAY);
    supply_low = 1'b0;
    run_len(1'b0, 100);
    rng(n, 36, 44);
  endtask
  // Clock, 200 MHz
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Main sequence
  initial begin
    errors = 0;
    checked = 0;
    rst_n = 1'b0;
    supply_low = 1'b0;
    disable_level = 1'b0;
    kick_en = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    t_power();
    t_kick();
    t_disable();
    t_supply();
    t_fault_dis();
    finish_test();
  end
endmodule

// *** src/swt_defines.svh ***
// Timing constants for the supply watchdog timer.
`ifndef SWT_DEFINES_SVH
`define SWT_DEFINES_SVH
// Clock rate in kHz (200 MHz)
`define SWT_CLK_KHZ 200000
// Times in microseconds, typical figures
`define SWT_RESET_DELAY_US 8500
`define SWT_IGNORE_TIME_US 16000
`define SWT_KICK_DEADLINE_US 48000
`define SWT_FAULT_PULSE_US 8000
`define SWT_FILTER_MIN_US 100
`define SWT_FILTER_MAX_US 500
// Cycles derived from the times
`define SWT_CYC(us) ((us) * (`SWT_CLK_KHZ / 1000))
// Oscillator tick: one enable per microsecond
`define SWT_TICK_DIV (`SWT_CLK_KHZ / 1000)
// Filter qualification in ticks, between the min and max figures
`define SWT_FILTER_TICKS 200
`endif

// *** src/swt_pkg.sv ***
// Types for the supply watchdog timer.
package swt_pkg;
  typedef enum logic [2:0] {
    SWT_RESET_DELAY,
    SWT_IGNORE,
    SWT_TRIGGER,
    SWT_FAULT,
    SWT_DISABLED
  } swt_state_t;
endpackage

// *** src/swt_tick_if.sv ***
// Oscillator tick carrier between the timebase and the watchdog core.
`timescale 1ns/1ps
interface swt_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// *** src/swt_timebase.sv ***
// Free-running internal timebase producing a 1 us enable pulse.
`timescale 1ns/1ps
`include "swt_defines.svh"
module swt_timebase #(
  parameter int DIV = `SWT_TICK_DIV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Tick out
  swt_tick_if.src tb
);
  import swt_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } swt_tb_t;
  swt_tb_t st_r, st_nxt;

  // Refuse divisors that the 16-bit counter cannot serve
  if (DIV < 2 || DIV > 65535) begin : g_bad_div
    $error("swt_timebase: bad DIV");
  end

  // -----------------------------------------------------------
  // Divider
  // -----------------------------------------------------------
  // Free-running count, never restarted by the watchdog
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == 16'(DIV - 1)) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tb.tick = st_r.tick;
endmodule

// *** src/swt_watchdog.sv ***
// Supply watchdog timer core with shared active-low fault/reset output.
`timescale 1ns/1ps
`include "swt_defines.svh"
module swt_watchdog #(
  parameter int RESET_DELAY_TICKS = `SWT_RESET_DELAY_US,
  parameter int IGNORE_TICKS = `SWT_IGNORE_TIME_US,
  parameter int DEADLINE_TICKS = `SWT_KICK_DEADLINE_US,
  parameter int FAULT_TICKS = `SWT_FAULT_PULSE_US,
  parameter int FILTER_TICKS = `SWT_FILTER_TICKS,
  parameter int TICK_DIV = `SWT_TICK_DIV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Supply monitor: high while output voltage is below threshold
  input wire logic supply_low,
  // Kick input: logic level and mid-level disable detector
  input wire logic kick_input,
  input wire logic disable_level,
  // Shared fault/reset pin, open drain
  output logic shared_fault_out,
  output logic shared_fault_oe_n,
  // Status
  output swt_pkg::swt_state_t wd_state
);
  import swt_pkg::*;

  localparam int TW = 16;

  typedef struct packed {
    swt_state_t state;
    logic [TW-1:0] tmr;
    logic [TW-1:0] flt;
    logic kick_s1;
    logic kick_s2;
    logic kick_s3;
    logic dis_s1;
    logic dis_s2;
    logic dis_q;
    logic fault_oe_n;
  } swt_st_t;

  swt_st_t st_r, st_nxt;
  swt_tick_if tbi();

  // Refuse counts the 16-bit timers or the filter window cannot serve
  if (RESET_DELAY_TICKS < 1 || RESET_DELAY_TICKS > 65535 ||
      IGNORE_TICKS < 1 || IGNORE_TICKS > 65535 ||
      DEADLINE_TICKS < 1 || DEADLINE_TICKS > 65535 ||
      FAULT_TICKS < 1 || FAULT_TICKS > 65535 ||
      FILTER_TICKS < 100 || FILTER_TICKS > 499) begin : g_bad_timing
    $error("swt_watchdog: timing parameter out of range");
  end

  // Microsecond enable from the internal timebase
  swt_timebase #(.DIV(TICK_DIV)) u_tb (
    .mclk(mclk),
    .rst_n(rst_n),
    .tb(tbi.src)
  );

  function automatic logic [TW-1:0] tk(input int n);
    return TW'(n - 1);
  endfunction

  // -----------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------
  logic fall;
  always_comb begin
    st_nxt = st_r;
    // Two-stage synchroniser, edge on stages two and three
    st_nxt.kick_s1 = kick_input;
    st_nxt.kick_s2 = st_r.kick_s1;
    st_nxt.kick_s3 = st_r.kick_s2;
    st_nxt.dis_s1 = disable_level;
    st_nxt.dis_s2 = st_r.dis_s1;
    fall = st_r.kick_s3 & ~st_r.kick_s2; // Only falling edges count
    // Mode filter: level must persist FILTER_TICKS us
    if (st_r.dis_s2 == st_r.dis_q) begin
      st_nxt.flt = '0;
    end else if (tbi.tick) begin
      if (st_r.flt == tk(FILTER_TICKS)) begin
        st_nxt.dis_q = st_r.dis_s2;
        st_nxt.flt = '0;
      end else begin
        st_nxt.flt = st_r.flt + 1'b1;
      end
    end
    if (tbi.tick) st_nxt.tmr = st_r.tmr + 1'b1;
    unique case (st_r.state)
      SWT_RESET_DELAY: begin
        // Low for typ 8.5 ms, then release and ignore, or go to disabled if the filtered mode is disabled
        if (tbi.tick && st_r.tmr == tk(RESET_DELAY_TICKS)) begin
          st_nxt.state = st_r.dis_q ? SWT_DISABLED : SWT_IGNORE;
          st_nxt.tmr = '0;
        end
      end
      SWT_IGNORE: begin
        if (st_r.dis_q) begin
          st_nxt.state = SWT_DISABLED;
        end else if (tbi.tick && st_r.tmr == tk(IGNORE_TICKS)) begin
          st_nxt.state = SWT_TRIGGER;
          st_nxt.tmr = '0;
        end
      end
      SWT_TRIGGER: begin
        if (st_r.dis_q) begin
          st_nxt.state = SWT_DISABLED;
        end else if (fall) begin
          st_nxt.tmr = '0; // Restart deadline
        end else if (tbi.tick && st_r.tmr == tk(DEADLINE_TICKS)) begin
          st_nxt.state = SWT_FAULT;
          st_nxt.tmr = '0;
        end
      end
      SWT_FAULT: begin
        // Pulse completes even if disabled meanwhile; only a supply fault cuts it short
        if (tbi.tick && st_r.tmr == tk(FAULT_TICKS)) begin
          st_nxt.state = st_r.dis_q ? SWT_DISABLED : SWT_IGNORE;
          st_nxt.tmr = '0;
        end
      end
      SWT_DISABLED: begin
        st_nxt.tmr = '0;
        if (!st_r.dis_q) st_nxt.state = SWT_IGNORE;
      end
    endcase
    // Supply fault overrides everything and restarts delay
    if (supply_low) begin
      st_nxt.state = SWT_RESET_DELAY;
      st_nxt.tmr = '0;
    end
    // One shared active-low output for both causes
    st_nxt.fault_oe_n = !((st_nxt.state == SWT_RESET_DELAY) ||
                          (st_nxt.state == SWT_FAULT));
  end

  // -----------------------------------------------------------
  // State register
  // -----------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.state <= SWT_RESET_DELAY;
      st_r.fault_oe_n <= 1'b0;
      st_r.kick_s1 <= 1'b1;
      st_r.kick_s2 <= 1'b1;
      st_r.kick_s3 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output pulls low with enable low; released pin floats high.
  // Enable is held in its own flop so the pin has no logic in front
  assign shared_fault_out = 1'b0;
  assign shared_fault_oe_n = st_r.fault_oe_n;
  assign wd_state = st_r.state;

  // -----------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------
  property p_pin_low_states;
    @(posedge mclk) disable iff (!rst_n)
      (st_r.state == SWT_RESET_DELAY || st_r.state == SWT_FAULT)
      == !shared_fault_oe_n;
  endproperty
  a_pin_low_states: assert property (p_pin_low_states)
    else $error("pin drive does not match state");

  property p_disabled_high;
    @(posedge mclk) disable iff (!rst_n)
      st_r.state == SWT_DISABLED |-> shared_fault_oe_n;
  endproperty
  a_disabled_high: assert property (p_disabled_high)
    else $error("pin low while disabled");

  property p_kick_restart;
    @(posedge mclk) disable iff (!rst_n)
      st_r.state == SWT_TRIGGER && fall && !st_r.dis_q && !supply_low
      |=> st_r.tmr == '0;
  endproperty
  a_kick_restart: assert property (p_kick_restart)
    else $error("kick did not restart deadline");

  property p_supply_override;
    @(posedge mclk) disable iff (!rst_n)
      supply_low |=> st_r.state == SWT_RESET_DELAY && !shared_fault_oe_n;
  endproperty
  a_supply_override: assert property (p_supply_override)
    else $error("supply fault not overriding");

  property p_fault_to_ignore;
    @(posedge mclk) disable iff (!rst_n)
      st_r.state == SWT_FAULT && st_nxt.state != SWT_FAULT && !supply_low
      && !st_r.dis_q |=> st_r.state == SWT_IGNORE;
  endproperty
  a_fault_to_ignore: assert property (p_fault_to_ignore)
    else $error("fault end did not start ignore");

  property p_reenable;
    @(posedge mclk) disable iff (!rst_n)
      st_r.state == SWT_DISABLED && !st_r.dis_q && !supply_low
      |=> st_r.state == SWT_IGNORE;
  endproperty
  a_reenable: assert property (p_reenable)
    else $error("re-enable did not start ignore");

  property p_filter_hold;
    @(posedge mclk) disable iff (!rst_n)
      $changed(st_r.dis_q) |-> $past(st_r.dis_s2) == st_r.dis_q &&
      $past(st_r.flt) == TW'(FILTER_TICKS - 1);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("mode changed without full filter");

  property p_ignore_to_trigger;
    @(posedge mclk) disable iff (!rst_n)
      $rose(st_r.state == SWT_TRIGGER) |-> $past(st_r.state) == SWT_IGNORE
      && $past(st_r.tmr) == TW'(IGNORE_TICKS - 1);
  endproperty
  a_ignore_to_trigger: assert property (p_ignore_to_trigger)
    else $error("trigger period opened early");

  property p_fault_entry;
    @(posedge mclk) disable iff (!rst_n)
      $rose(st_r.state == SWT_FAULT) |-> $past(st_r.state) == SWT_TRIGGER
      && $past(st_r.tmr) == TW'(DEADLINE_TICKS - 1);
  endproperty
  a_fault_entry: assert property (p_fault_entry)
    else $error("fault without expired deadline");
endmodule
